// ### pkg/pec_pkg.sv
// shared constants and types of the performance event counter block
package pec_pkg;

  // ==========================================================================
  // sizes and reset values
  localparam int PEC_NUM_CH = 4;
  localparam int PEC_CNT_W = 32;
  localparam logic [31:0] PEC_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] PEC_COUNT_MAX = 32'hFFFF_FFFF;
  localparam logic [1:0] PEC_STEP_ONE = 2'h1;
  localparam logic [1:0] PEC_STEP_BRANCH = 2'h2;

  // ==========================================================================
  // event source per channel, coded 0 to 9 in this order
  typedef enum logic [3:0] {
    PEC_SRC_DISABLED,
    PEC_SRC_ELAPSED_CYCLE_SOURCE,
    PEC_SRC_EXECUTION_STATE_SOURCE,
    PEC_SRC_BRANCH_SOURCE,
    PEC_SRC_INSTRUCTION,
    PEC_SRC_EXCEPTION_INTERRUPT_SOURCE,
    PEC_SRC_INTERRUPT_ONLY,
    PEC_SRC_USER_RAM_ACCESS_SOURCE,
    PEC_SRC_USER_RAM_FETCH_SOURCE,
    PEC_SRC_USER_RAM_DATA_SOURCE
  } pec_src_t;

  // measurement period selection
  typedef enum logic [1:0] {
    PEC_PERIOD_COND1_TO_COND2,
    PEC_PERIOD_COND2_TO_COND1,
    PEC_PERIOD_START_TO_BREAK
  } pec_period_t;

  // measurement phase
  typedef enum logic [1:0] {
    PEC_PH_IDLE,
    PEC_PH_RUN,
    PEC_PH_DONE,
    PEC_PH_HALTED
  } pec_phase_t;

  // one-cycle event pulses from the cpu, all on i_clk
  typedef struct packed {
    logic exec_cycle;
    logic exec_state;
    logic branch;
    logic instr;
    logic exc_or_int;
    logic interrupt;
    logic user_ram_area_fetch;
    logic user_ram_area_data;
  } pec_events_t;

  // whole state of the block
  typedef struct packed {
    pec_phase_t phase;
    logic [PEC_NUM_CH-1:0][PEC_CNT_W-1:0] count;
    logic [PEC_NUM_CH-1:0] ovf;
    logic unreliable;
    // registered copies of the phase decode, so the status pins come from flops
    logic active;
    logic halted;
  } pec_state_t;

endpackage

// ### logic/pec_top.sv
// performance event counters: four channels over a bounded measurement period
`timescale 1ns/1ps
`default_nettype none

module pec_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cpu_clk_en,
  input wire pec_pkg::pec_events_t i_ev,
  input wire pec_pkg::pec_src_t [pec_pkg::PEC_NUM_CH-1:0] i_src_sel,
  input wire pec_pkg::pec_period_t i_period,
  input wire logic i_cond1_hit,
  input wire logic i_cond2_hit,
  input wire logic i_prog_start,
  input wire logic i_break,
  input wire logic i_por,
  input wire logic i_trace_nrt,
  input wire logic i_init,
  output logic [pec_pkg::PEC_NUM_CH-1:0][pec_pkg::PEC_CNT_W-1:0] o_count,
  output logic [pec_pkg::PEC_NUM_CH-1:0] o_ovf,
  output logic o_active,
  output logic o_halted,
  output logic o_unreliable
);

  // ==========================================================================
  // step per source
  // exceptions include interrupts, so the two interrupt sources differ only in
  // which pulse they watch; a user ram access that fetches and moves data in
  // one cycle counts twice, once per access
  function automatic logic [1:0] pec_step(input pec_pkg::pec_src_t sel, input pec_pkg::pec_events_t ev);
    logic [1:0] step;
    step = 2'h0;
    case (sel)
      pec_pkg::PEC_SRC_DISABLED: step = 2'h0;
      pec_pkg::PEC_SRC_ELAPSED_CYCLE_SOURCE: step = ev.exec_cycle ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_EXECUTION_STATE_SOURCE: step = ev.exec_state ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_BRANCH_SOURCE: step = ev.branch ? pec_pkg::PEC_STEP_BRANCH : 2'h0;
      pec_pkg::PEC_SRC_INSTRUCTION: step = ev.instr ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_EXCEPTION_INTERRUPT_SOURCE: step = ev.exc_or_int ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_INTERRUPT_ONLY: step = ev.interrupt ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_USER_RAM_ACCESS_SOURCE: step = {1'b0, ev.user_ram_area_fetch} + {1'b0, ev.user_ram_area_data};
      pec_pkg::PEC_SRC_USER_RAM_FETCH_SOURCE: step = ev.user_ram_area_fetch ? pec_pkg::PEC_STEP_ONE : 2'h0;
      pec_pkg::PEC_SRC_USER_RAM_DATA_SOURCE: step = ev.user_ram_area_data ? pec_pkg::PEC_STEP_ONE : 2'h0;
      default: step = 2'h0;
    endcase
    return step;
  endfunction

  // ==========================================================================
  // period control terms
  pec_pkg::pec_state_t st;
  pec_pkg::pec_state_t next_st;
  logic start_hit;
  logic end_hit;
  logic counting;
  logic cond_mode;
  logic [pec_pkg::PEC_CNT_W:0] sum [pec_pkg::PEC_NUM_CH];

  // a condition that coincides with a power-on reset is not taken as satisfied
  always_comb
  begin
    start_hit = 1'b0;
    end_hit = 1'b0;
    cond_mode = 1'b0;
    case (i_period)
      pec_pkg::PEC_PERIOD_COND1_TO_COND2:
      begin
        cond_mode = 1'b1;
        start_hit = i_cond1_hit & ~i_por;
        end_hit = i_cond2_hit & ~i_por;
      end
      pec_pkg::PEC_PERIOD_COND2_TO_COND1:
      begin
        cond_mode = 1'b1;
        start_hit = i_cond2_hit & ~i_por;
        end_hit = i_cond1_hit & ~i_por;
      end
      default:
      begin
        start_hit = i_prog_start;
        end_hit = i_break;
      end
    endcase
  end

  // stalled cpu clock freezes every channel, as does any phase but run
  assign counting = (st.phase == pec_pkg::PEC_PH_RUN) && i_cpu_clk_en;

  // ==========================================================================
  // next state
  always_comb
  begin
    next_st = st;
    // phase sequence; a finished or halted period waits for initialize
    case (st.phase)
      pec_pkg::PEC_PH_IDLE:
      begin
        if (start_hit)
          next_st.phase = pec_pkg::PEC_PH_RUN;
      end
      pec_pkg::PEC_PH_RUN:
      begin
        // both start-to-break codes have no conditions, so power-on reset is ignored there
        if (i_por && cond_mode)
          next_st.phase = pec_pkg::PEC_PH_HALTED;
        else if (end_hit)
          next_st.phase = pec_pkg::PEC_PH_DONE;
      end
      pec_pkg::PEC_PH_DONE: next_st.phase = pec_pkg::PEC_PH_DONE;
      pec_pkg::PEC_PH_HALTED: next_st.phase = pec_pkg::PEC_PH_HALTED;
      default: next_st.phase = pec_pkg::PEC_PH_IDLE;
    endcase
    if (i_init)
      next_st.phase = pec_pkg::PEC_PH_IDLE;
    // status flops follow the next phase, so they keep the phase's cycle timing
    next_st.active = (next_st.phase == pec_pkg::PEC_PH_RUN);
    next_st.halted = (next_st.phase == pec_pkg::PEC_PH_HALTED);
    // channels run side by side; initialize zeroes the base, so an event in
    // the same cycle still lands on the fresh count instead of being lost
    for (int c = 0; c < pec_pkg::PEC_NUM_CH; c++)
    begin
      sum[c] = {1'b0, (i_init ? pec_pkg::PEC_COUNT_RST : st.count[c])}
               + {31'h0000_0000, (counting ? pec_step(i_src_sel[c], i_ev) : 2'h0)};
      next_st.count[c] = sum[c][pec_pkg::PEC_CNT_W-1:0];
      next_st.ovf[c] = (st.ovf[c] & ~i_init) | sum[c][pec_pkg::PEC_CNT_W];
    end
    // trace mode bends stall timing, so flag the run rather than trust it
    next_st.unreliable = (st.unreliable & ~i_init) | (counting & i_trace_nrt);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st.phase <= pec_pkg::PEC_PH_IDLE;
      st.count <= {pec_pkg::PEC_NUM_CH{pec_pkg::PEC_COUNT_RST}};
      st.ovf <= '0;
      st.unreliable <= 1'b0;
      st.active <= 1'b0;
      st.halted <= 1'b0;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state flops
  assign o_count = st.count;
  assign o_ovf = st.ovf;
  assign o_active = st.active;
  assign o_halted = st.halted;
  assign o_unreliable = st.unreliable;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_src_disabled: assert property (
    i_src_sel[0] == pec_pkg::PEC_SRC_DISABLED && !i_init |=> $stable(o_count[0]))
    else $error("disabled channel changed its count");

  chk_cycle_step: assert property (
    counting && i_src_sel[0] == pec_pkg::PEC_SRC_ELAPSED_CYCLE_SOURCE && i_ev.exec_cycle && !i_init
    && o_count[0] != pec_pkg::PEC_COUNT_MAX |=> o_count[0] == $past(o_count[0]) + 32'h0000_0001)
    else $error("elapsed cycle did not add one");

  chk_branch_step: assert property (
    counting && i_src_sel[1] == pec_pkg::PEC_SRC_BRANCH_SOURCE && i_ev.branch && !i_init
    && o_count[1] < 32'hFFFF_FFF0 |=> o_count[1] == $past(o_count[1]) + 32'h0000_0002)
    else $error("branch did not add two");

  chk_clock_stop: assert property (
    !i_cpu_clk_en && !i_init |=> $stable(o_count) && $stable(o_ovf))
    else $error("count moved while cpu clock stopped");

  chk_por_halt: assert property (
    o_active && i_por && !i_init && cond_mode
    |=> o_halted && !o_active ##1 (o_halted || $past(i_init)))
    else $error("power-on reset did not halt the period");

  chk_ovf_wrap: assert property (
    counting && i_src_sel[0] == pec_pkg::PEC_SRC_ELAPSED_CYCLE_SOURCE && i_ev.exec_cycle && !i_init
    && o_count[0] == pec_pkg::PEC_COUNT_MAX |=> o_ovf[0] && o_count[0] == pec_pkg::PEC_COUNT_RST)
    else $error("wrap did not raise overflow");

  chk_init_clear: assert property (
    i_init && !counting |=> o_count == '0 && o_ovf == '0 && !o_active)
    else $error("initialize left results behind");

  chk_nrt_flag: assert property (
    counting && i_trace_nrt |=> o_unreliable ##1 (o_unreliable || $past(i_init)))
    else $error("trace mode count not flagged");

  chk_period_start: assert property (
    st.phase == pec_pkg::PEC_PH_IDLE && start_hit && !i_init |=> o_active)
    else $error("start condition did not open the period");

  chk_hold_outside: assert property (
    !o_active && !i_init |=> $stable(o_count))
    else $error("count moved outside the period");

  cov_branch_run: cover property (counting && i_ev.branch && i_src_sel[0] == pec_pkg::PEC_SRC_BRANCH_SOURCE);
  cov_period_done: cover property (o_active ##[1:50] st.phase == pec_pkg::PEC_PH_DONE);
  cov_por_halt: cover property (o_active ##1 o_halted);
  cov_overflow: cover property ($rose(o_ovf[0]));

endmodule // pec_top

`default_nettype wire

// ### tb/pec_cpu_model.sv
// cpu side model: clock enable and free-running event pulses
`timescale 1ns/1ps
`default_nettype none

module pec_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output var pec_pkg::pec_events_t o_ev,
  output logic o_clk_en
);
  // ==========================================================================
  // events keep coming while the clock is stopped, so the block must gate them
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ev <= '0;
      o_clk_en <= 1'b0;
    end
    else
    begin
      o_clk_en <= ($urandom % 8) != 0;
      o_ev <= pec_pkg::pec_events_t'($urandom);
    end
  end
endmodule // pec_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the performance event counters
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================================
  // stimulus and reference state
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cond1 = 1'b0, cond2 = 1'b0, start = 1'b0, brk = 1'b0, por = 1'b0, nrt = 1'b0, init = 1'b0;
  pec_pkg::pec_events_t ev;
  logic clk_en;
  pec_pkg::pec_src_t [pec_pkg::PEC_NUM_CH-1:0] sel;
  pec_pkg::pec_period_t period;
  logic [pec_pkg::PEC_NUM_CH-1:0][pec_pkg::PEC_CNT_W-1:0] o_count;
  logic [pec_pkg::PEC_NUM_CH-1:0] o_ovf;
  logic o_active, o_halted, o_unreliable;
  pec_pkg::pec_phase_t ph;
  logic unrel;
  logic [pec_pkg::PEC_NUM_CH-1:0][31:0] cnt;
  int fails = 0;
  int n_tests = 0;
  // hits as the block should see them; a condition hit together with por is lost
  wire s_hit = period[1] ? start : ((period[0] ? cond2 : cond1) && !por);
  wire e_hit = period[1] ? brk : ((period[0] ? cond1 : cond2) && !por);

  always #4 i_clk = ~i_clk;

  pec_cpu_model i_pec_cpu_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_ev(ev), .o_clk_en(clk_en));

  pec_top i_pec_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cpu_clk_en(clk_en), .i_ev(ev), .i_src_sel(sel),
    .i_period(period), .i_cond1_hit(cond1), .i_cond2_hit(cond2), .i_prog_start(start), .i_break(brk),
    .i_por(por), .i_trace_nrt(nrt), .i_init(init), .o_count(o_count), .o_ovf(o_ovf),
    .o_active(o_active), .o_halted(o_halted), .o_unreliable(o_unreliable));

  // ==========================================================================
  // expected step of one channel for one cycle
  function automatic logic [31:0] step_of(input pec_pkg::pec_src_t s, input pec_pkg::pec_events_t e);
    case (s)
      pec_pkg::PEC_SRC_ELAPSED_CYCLE_SOURCE: step_of = 32'(e.exec_cycle);
      pec_pkg::PEC_SRC_EXECUTION_STATE_SOURCE: step_of = 32'(e.exec_state);
      pec_pkg::PEC_SRC_BRANCH_SOURCE: step_of = e.branch ? 32'h2 : 32'h0;
      pec_pkg::PEC_SRC_INSTRUCTION: step_of = 32'(e.instr);
      pec_pkg::PEC_SRC_EXCEPTION_INTERRUPT_SOURCE: step_of = 32'(e.exc_or_int);
      pec_pkg::PEC_SRC_INTERRUPT_ONLY: step_of = 32'(e.interrupt);
      pec_pkg::PEC_SRC_USER_RAM_ACCESS_SOURCE: step_of = 32'(e.user_ram_area_fetch) + 32'(e.user_ram_area_data);
      pec_pkg::PEC_SRC_USER_RAM_FETCH_SOURCE: step_of = 32'(e.user_ram_area_fetch);
      pec_pkg::PEC_SRC_USER_RAM_DATA_SOURCE: step_of = 32'(e.user_ram_area_data);
      default: step_of = 32'h0;
    endcase
  endfunction

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // reference model, one step per edge from the values before the edge
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ph <= pec_pkg::PEC_PH_IDLE;
      cnt <= '0;
      unrel <= 1'b0;
    end
    else
    begin
      unrel <= (unrel && !init) || (ph == pec_pkg::PEC_PH_RUN && clk_en && nrt);
      for (int c = 0; c < pec_pkg::PEC_NUM_CH; c++)
        cnt[c] <= (init ? 32'h0 : cnt[c]) + ((ph == pec_pkg::PEC_PH_RUN && clk_en) ? step_of(sel[c], ev) : 32'h0);
      if (init)
        ph <= pec_pkg::PEC_PH_IDLE;
      else if (ph == pec_pkg::PEC_PH_RUN && por && !period[1])
        ph <= pec_pkg::PEC_PH_HALTED;
      else if (ph == pec_pkg::PEC_PH_RUN && e_hit)
        ph <= pec_pkg::PEC_PH_DONE;
      else if (ph == pec_pkg::PEC_PH_IDLE && s_hit)
        ph <= pec_pkg::PEC_PH_RUN;
    end
  end

  // compare mid-cycle, where every output has settled
  always @(negedge i_clk)
  begin
    if (i_rst_n)
    begin
      check(o_count, cnt);
      check(128'(o_ovf), 128'h0);
      check(128'(o_unreliable), 128'(unrel));
      check(128'({o_active, o_halted}), 128'({ph == pec_pkg::PEC_PH_RUN, ph == pec_pkg::PEC_PH_HALTED}));
    end
  end

  // ==========================================================================
  // random controls, with init plus a cond1 hit in the same cycle as a corner
  initial
  begin
    void'($urandom(19));
    period = pec_pkg::PEC_PERIOD_COND1_TO_COND2;
    sel = {4{pec_pkg::PEC_SRC_BRANCH_SOURCE}};
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8000; i++)
    begin
      @(posedge i_clk);
      init <= ($urandom % 64) == 0 || (i % 200) == 1;
      cond1 <= ($urandom % 16) == 0 || (i % 200) == 1;
      cond2 <= ($urandom % 16) == 0;
      start <= ($urandom % 16) == 0;
      brk <= ($urandom % 24) == 0;
      por <= ($urandom % 48) == 0;
      nrt <= ($urandom % 32) == 0;
      if ((i % 200) == 1)
      begin
        period <= pec_pkg::pec_period_t'($urandom % 4);
        for (int c = 0; c < pec_pkg::PEC_NUM_CH; c++)
          sel[c] <= pec_pkg::pec_src_t'(($urandom + c) % 16);
      end
      // reset in mid-run must bring everything back to zero
      if (i == 4000)
        i_rst_n <= 1'b0;
      if (i == 4002)
        i_rst_n <= 1'b1;
    end
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
